// >>> hw/dptr_pkg.sv
/*
 * Shared constants and carriers for the data pointer register block.
 * Assumes a word-addressed memory-mapped register port and a core
 * decoder that issues dedicated register writes and stack strobes.
 */
package dptr_pkg;
	localparam int PAGE_W = 7;
	localparam int WORD_W = 16;
	localparam int ADDR_W = 23;
	localparam int IO_PAGE_W = 9;
	localparam int IO_PAGE_SHIFT = 7;
	localparam int MMR_AW = 16;
	localparam int N_START = 5;
	localparam int N_SIZE = 3;
	localparam int SEL_W = 4;

	// pointer select codes on the address request
	localparam logic [3:0] SEL_COEF = 4'h8;
	localparam logic [3:0] SEL_AUX_HIGH = 4'h4;
	localparam int START_COEF = 4;
	localparam int SIZE_AUX_LOW = 0;
	localparam int SIZE_AUX_HIGH = 1;
	localparam int SIZE_COEF = 2;

	localparam logic [15:0] RST_WORD = 16'h0000;
	localparam logic [6:0] RST_PAGE = 7'h00;
	localparam logic [8:0] RST_IO_PAGE = 9'h000;

	// memory-mapped word offsets
	localparam logic [15:0] OFS_SSP = 16'h004c;
	localparam logic [15:0] OFS_SP = 16'h004d;
	localparam logic [15:0] OFS_SPH = 16'h004e;
	localparam logic [15:0] OFS_COEF_POINTER_PAGE = 16'h004f;
	localparam logic [15:0] OFS_CDP = 16'h0020;
	localparam logic [15:0] OFS_DP = 16'h0021;
	localparam logic [15:0] OFS_DPH = 16'h0022;
	localparam logic [15:0] OFS_PDP = 16'h0023;
	localparam logic [N_SIZE-1:0][15:0] OFS_SIZE = {
		16'h0026, 16'h0025, 16'h0024};
	localparam logic [N_START-1:0][15:0] OFS_START = {
		16'h002b, 16'h002a, 16'h0029, 16'h0028, 16'h0027};

	typedef enum logic [3:0] {
		DW_NONE = 4'h0,
		DW_COEF_LOW = 4'h1,
		DW_EXT_COEF = 4'h2,
		DW_PAGE_LOW = 4'h3,
		DW_PAGE_EXT = 4'h4,
		DW_EXT_PAGE = 4'h5,
		DW_IO_PAGE = 4'h6,
		DW_DSTK = 4'h7,
		DW_SSTK = 4'h8,
		DW_EXT_DSTK = 4'h9,
		DW_EXT_SSTK = 4'ha
	} ded_target_t;

	typedef struct packed {
		ded_target_t target;
		logic [ADDR_W-1:0] data;
	} ded_wr_t;

	typedef struct packed {
		logic sel;
		logic we;
		logic [MMR_AW-1:0] addr;
		logic [WORD_W-1:0] wdata;
	} mmr_req_t;

	typedef struct packed {
		logic valid;
		logic [SEL_W-1:0] sel;
		logic [ADDR_W-1:0] aux_ptr;
		logic circ_en;
		logic [WORD_W-1:0] step;
		logic advance;
	} agen_req_t;

	typedef struct packed {
		logic push;
		logic pop;
	} stk_op_t;
endpackage : dptr_pkg

// >>> hw/circ_addr_unit.sv
/*
 * Circular or linear address former for one pointer.
 * Purely combinational; the caller registers the results.
 */
`timescale 1ns/100ps
module circ_addr_unit #(
	parameter int PW = 7,
	parameter int WW = 16
) (
	input wire logic [PW-1:0] page, // main page of the pointer
	input wire logic [WW-1:0] index, // pointer low part
	input wire logic [WW-1:0] start, // buffer start value
	input wire logic [WW-1:0] size, // buffer length in words
	input wire logic circ_en, // pointer is circular
	input wire logic [WW-1:0] step, // signed modifier
	output logic [PW+WW-1:0] addr, // formed address
	output logic [WW-1:0] next_index // advanced low part
);
	logic [WW:0] sum;
	logic [WW-1:0] offs;

	always_comb begin
		sum = {1'b0, index} + {step[WW-1], step};
		next_index = sum[WW-1:0];
		if (circ_en && size != '0) begin
			if (!step[WW-1] && sum >= {1'b0, size})
				next_index = WW'(sum - {1'b0, size});
			else if (step[WW-1] && sum[WW])
				next_index = WW'(sum + {1'b0, size});
		end
		// carry out of the low half is dropped so the page never changes
		offs = circ_en ? WW'(start + index) : index;
		addr = {page, offs};
	end
endmodule : circ_addr_unit

// >>> hw/stack_ptr_unit.sv
/*
 * Next value of one 16-bit stack pointer.
 * A lone push or pop strobe wins over a software write in the same cycle; with both strobes set the write stands.
 */
`timescale 1ns/100ps
module stack_ptr_unit #(
	parameter int WW = 16
) (
	input wire logic [WW-1:0] cur, // current pointer
	input wire logic push, // decrement before the store
	input wire logic pop, // increment after the load
	input wire logic wr, // software write
	input wire logic [WW-1:0] wdata, // write value
	output logic [WW-1:0] nxt // next pointer
);
	always_comb begin
		nxt = cur;
		if (wr)
			nxt = wdata;
		if (push && !pop)
			nxt = WW'(cur - 1'b1);
		else if (pop && !push)
			nxt = WW'(cur + 1'b1);
	end
endmodule : stack_ptr_unit

// >>> hw/dsp_data_pointer_registers.sv
/*
 * Data-space and I/O-space pointer registers with address forming.
 * Assumes the decoder drives requests synchronous to sys_clk and that
 * auxiliary pointers and the circular enable arrive as inputs; buffer starts and sizes are mapped registers here.
 */
`timescale 1ns/100ps
module dsp_data_pointer_registers (
	input wire logic sys_clk, // core clock
	input wire logic nrst, // asynchronous reset, active low
	input wire dptr_pkg::mmr_req_t mmr, // memory-mapped access
	output logic [15:0] mmr_rdata, // read data of last read
	output logic mmr_hit, // last access matched a register
	input wire dptr_pkg::ded_wr_t ded_wr, // dedicated instruction write
	input wire dptr_pkg::stk_op_t dstk_op, // data stack strobes
	input wire dptr_pkg::stk_op_t sstk_op, // system stack strobes
	input wire dptr_pkg::agen_req_t agen, // indirect address request
	input wire logic legacy_compat_mode, // compatibility mode on
	input wire logic [15:0] absolute_16bit_immediate, // absolute offset
	output logic [22:0] agen_addr, // formed indirect address
	output logic [15:0] agen_next_index, // advanced pointer low part
	output logic agen_valid, // agen outputs updated
	output logic [22:0] extended_coef_pointer, // page and low part
	output logic [22:0] extended_page_value, // direct mode address
	output logic [22:0] abs_addr, // absolute mode address
	output logic [15:0] io_page_base, // first word of I/O page
	output logic [22:0] extended_data_stack_pointer, // data stack top
	output logic [22:0] extended_system_stack_pointer // system stack top
);
	typedef struct packed {
		logic [15:0] coef_pointer_low;
		logic [6:0] coef_pointer_page;
		logic [dptr_pkg::N_START-1:0][15:0] circ_start;
		logic [dptr_pkg::N_SIZE-1:0][15:0] circ_size;
		logic [15:0] local_page_offset;
		logic [6:0] main_page_extension;
		logic [8:0] io_page_select;
		logic [15:0] data_stack_pointer;
		logic [15:0] system_stack_pointer;
		logic [6:0] stack_page_extension;
		logic [15:0] mmr_rdata;
		logic mmr_hit;
		logic [22:0] agen_addr;
		logic [15:0] agen_next;
		logic agen_valid;
		logic [22:0] abs_addr;
	} state_t;

	localparam state_t STATE_RST = '{
		coef_pointer_low: dptr_pkg::RST_WORD,
		coef_pointer_page: dptr_pkg::RST_PAGE,
		circ_start: '0,
		circ_size: '0,
		local_page_offset: dptr_pkg::RST_WORD,
		main_page_extension: dptr_pkg::RST_PAGE,
		io_page_select: dptr_pkg::RST_IO_PAGE,
		data_stack_pointer: dptr_pkg::RST_WORD,
		system_stack_pointer: dptr_pkg::RST_WORD,
		stack_page_extension: dptr_pkg::RST_PAGE,
		mmr_rdata: dptr_pkg::RST_WORD,
		mmr_hit: 1'b0,
		agen_addr: '0,
		agen_next: dptr_pkg::RST_WORD,
		agen_valid: 1'b0,
		abs_addr: '0
	};

	state_t s_r;
	state_t s_nxt;
	logic mw;
	logic mr;
	logic is_coef;
	logic [2:0] start_sel;
	logic [1:0] size_sel;
	logic [6:0] sel_page;
	logic [15:0] sel_index;
	logic [22:0] circ_addr;
	logic [15:0] circ_next;
	logic dstk_wr;
	logic sstk_wr;
	logic [15:0] dstk_wdata;
	logic [15:0] sstk_wdata;
	logic [15:0] dstk_nxt;
	logic [15:0] sstk_nxt;
	logic [15:0] rd;
	logic rd_hit;

	assign mw = mmr.sel & mmr.we;
	assign mr = mmr.sel & ~mmr.we;

	// pointer pairing for start and size selection
	always_comb begin
		is_coef = agen.sel == dptr_pkg::SEL_COEF;
		start_sel = is_coef ? 3'(dptr_pkg::START_COEF) : agen.sel[3:1];
		if (is_coef)
			size_sel = 2'(dptr_pkg::SIZE_COEF);
		else if (agen.sel < dptr_pkg::SEL_AUX_HIGH || legacy_compat_mode)
			size_sel = 2'(dptr_pkg::SIZE_AUX_LOW);
		else
			size_sel = 2'(dptr_pkg::SIZE_AUX_HIGH);
		// each pointer supplies its own main page
		sel_page = is_coef ? s_r.coef_pointer_page
			: agen.aux_ptr[22:16];
		sel_index = is_coef ? s_r.coef_pointer_low
			: agen.aux_ptr[15:0];
	end

	circ_addr_unit #(
		.PW(dptr_pkg::PAGE_W),
		.WW(dptr_pkg::WORD_W)
	) u_circ (
		.page(sel_page),
		.index(sel_index),
		.start(s_r.circ_start[start_sel]),
		.size(s_r.circ_size[size_sel]),
		.circ_en(agen.circ_en),
		.step(agen.step),
		.addr(circ_addr),
		.next_index(circ_next)
	);

	// software writes to the stack pointers, dedicated or mapped
	always_comb begin
		dstk_wr = 1'b0;
		dstk_wdata = ded_wr.data[15:0];
		if (ded_wr.target == dptr_pkg::DW_DSTK
			|| ded_wr.target == dptr_pkg::DW_EXT_DSTK)
			dstk_wr = 1'b1;
		else if (mw && mmr.addr == dptr_pkg::OFS_SP) begin
			dstk_wr = 1'b1;
			dstk_wdata = mmr.wdata;
		end
		sstk_wr = 1'b0;
		sstk_wdata = ded_wr.data[15:0];
		if (ded_wr.target == dptr_pkg::DW_SSTK
			|| ded_wr.target == dptr_pkg::DW_EXT_SSTK)
			sstk_wr = 1'b1;
		else if (mw && mmr.addr == dptr_pkg::OFS_SSP) begin
			sstk_wr = 1'b1;
			sstk_wdata = mmr.wdata;
		end
	end

	stack_ptr_unit #(
		.WW(dptr_pkg::WORD_W)
	) u_dstk (
		.cur(s_r.data_stack_pointer),
		.push(dstk_op.push),
		.pop(dstk_op.pop),
		.wr(dstk_wr),
		.wdata(dstk_wdata),
		.nxt(dstk_nxt)
	);

	stack_ptr_unit #(
		.WW(dptr_pkg::WORD_W)
	) u_sstk (
		.cur(s_r.system_stack_pointer),
		.push(sstk_op.push),
		.pop(sstk_op.pop),
		.wr(sstk_wr),
		.wdata(sstk_wdata),
		.nxt(sstk_nxt)
	);

	// memory-mapped read mux; extended forms have no location
	always_comb begin
		rd = dptr_pkg::RST_WORD;
		rd_hit = 1'b1;
		case (mmr.addr)
			dptr_pkg::OFS_CDP: rd = s_r.coef_pointer_low;
			dptr_pkg::OFS_COEF_POINTER_PAGE: rd = {9'h000, s_r.coef_pointer_page};
			dptr_pkg::OFS_DP: rd = s_r.local_page_offset;
			dptr_pkg::OFS_DPH: rd = {9'h000, s_r.main_page_extension};
			dptr_pkg::OFS_PDP: rd = {7'h00, s_r.io_page_select};
			dptr_pkg::OFS_SP: rd = s_r.data_stack_pointer;
			dptr_pkg::OFS_SSP: rd = s_r.system_stack_pointer;
			dptr_pkg::OFS_SPH: rd = {9'h000, s_r.stack_page_extension};
			default: rd_hit = 1'b0;
		endcase
		for (int i = 0; i < dptr_pkg::N_START; i++) begin
			if (mmr.addr == dptr_pkg::OFS_START[i]) begin
				rd = s_r.circ_start[i];
				rd_hit = 1'b1;
			end
		end
		for (int i = 0; i < dptr_pkg::N_SIZE; i++) begin
			if (mmr.addr == dptr_pkg::OFS_SIZE[i]) begin
				rd = s_r.circ_size[i];
				rd_hit = 1'b1;
			end
		end
	end

	always_comb begin
		s_nxt = s_r;

		// mapped writes, lowest priority
		if (mw) begin
			case (mmr.addr)
				dptr_pkg::OFS_CDP:
					s_nxt.coef_pointer_low = mmr.wdata;
				dptr_pkg::OFS_COEF_POINTER_PAGE:
					s_nxt.coef_pointer_page = mmr.wdata[6:0];
				dptr_pkg::OFS_DP:
					s_nxt.local_page_offset = mmr.wdata;
				dptr_pkg::OFS_DPH:
					s_nxt.main_page_extension = mmr.wdata[6:0];
				dptr_pkg::OFS_PDP:
					s_nxt.io_page_select = mmr.wdata[8:0];
				dptr_pkg::OFS_SPH:
					s_nxt.stack_page_extension = mmr.wdata[6:0];
				default: ;
			endcase
			for (int i = 0; i < dptr_pkg::N_START; i++)
				if (mmr.addr == dptr_pkg::OFS_START[i])
					s_nxt.circ_start[i] = mmr.wdata;
			for (int i = 0; i < dptr_pkg::N_SIZE; i++)
				if (mmr.addr == dptr_pkg::OFS_SIZE[i])
					s_nxt.circ_size[i] = mmr.wdata;
		end

		// dedicated instruction writes win over mapped ones
		case (ded_wr.target)
			dptr_pkg::DW_COEF_LOW:
				s_nxt.coef_pointer_low = ded_wr.data[15:0];
			dptr_pkg::DW_EXT_COEF: begin
				s_nxt.coef_pointer_low = ded_wr.data[15:0];
				s_nxt.coef_pointer_page = ded_wr.data[22:16];
			end
			dptr_pkg::DW_PAGE_LOW:
				s_nxt.local_page_offset = ded_wr.data[15:0];
			dptr_pkg::DW_PAGE_EXT:
				s_nxt.main_page_extension = ded_wr.data[6:0];
			dptr_pkg::DW_EXT_PAGE: begin
				s_nxt.local_page_offset = ded_wr.data[15:0];
				s_nxt.main_page_extension = ded_wr.data[22:16];
			end
			dptr_pkg::DW_IO_PAGE:
				s_nxt.io_page_select = ded_wr.data[8:0];
			dptr_pkg::DW_EXT_DSTK, dptr_pkg::DW_EXT_SSTK:
				s_nxt.stack_page_extension = ded_wr.data[22:16];
			default: ;
		endcase

		// stack pointers step without touching the shared page
		s_nxt.data_stack_pointer = dstk_nxt;
		s_nxt.system_stack_pointer = sstk_nxt;

		// indirect address; coefficient index advances in place
		s_nxt.agen_valid = agen.valid;
		if (agen.valid) begin
			s_nxt.agen_addr = circ_addr;
			s_nxt.agen_next = agen.advance ? circ_next : sel_index;
			if (is_coef && agen.advance)
				s_nxt.coef_pointer_low = circ_next;
		end

		s_nxt.abs_addr = {s_r.main_page_extension,
			absolute_16bit_immediate};

		if (mr) begin
			s_nxt.mmr_rdata = rd;
			s_nxt.mmr_hit = rd_hit;
		end else if (mw) begin
			s_nxt.mmr_hit = rd_hit;
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst)
			s_r <= STATE_RST;
		else
			s_r <= s_nxt;
	end

	assign mmr_rdata = s_r.mmr_rdata;
	assign mmr_hit = s_r.mmr_hit;
	assign agen_addr = s_r.agen_addr;
	assign agen_next_index = s_r.agen_next;
	assign agen_valid = s_r.agen_valid;
	assign extended_coef_pointer = {s_r.coef_pointer_page,
		s_r.coef_pointer_low};
	assign extended_page_value = {s_r.main_page_extension,
		s_r.local_page_offset};
	assign abs_addr = s_r.abs_addr;
	// page number times page size gives the I/O word address
	assign io_page_base = {s_r.io_page_select,
		{dptr_pkg::IO_PAGE_SHIFT{1'b0}}};
	assign extended_data_stack_pointer = {s_r.stack_page_extension,
		s_r.data_stack_pointer};
	assign extended_system_stack_pointer = {s_r.stack_page_extension,
		s_r.system_stack_pointer};
endmodule : dsp_data_pointer_registers

// >>> tb/dptr_monitor.sv
/*
 * Port-level checks of the data pointer register block.
 * Bound to the top module; sees only its ports.
 */
`timescale 1ns/100ps
module dptr_monitor (
	input wire logic sys_clk, // core clock
	input wire logic nrst, // reset, active low
	input wire dptr_pkg::mmr_req_t mmr, // mapped access
	input wire dptr_pkg::ded_wr_t ded_wr, // dedicated write
	input wire dptr_pkg::stk_op_t dstk_op, // data stack strobes
	input wire dptr_pkg::stk_op_t sstk_op, // system stack strobes
	input wire dptr_pkg::agen_req_t agen, // address request
	input wire logic [15:0] absolute_16bit_immediate, // absolute offset
	input wire logic [15:0] mmr_rdata, // read data
	input wire logic mmr_hit, // access matched
	input wire logic [22:0] agen_addr, // formed address
	input wire logic agen_valid, // address valid
	input wire logic [22:0] extended_coef_pointer, // coef pointer
	input wire logic [22:0] extended_page_value, // direct page
	input wire logic [22:0] abs_addr, // absolute address
	input wire logic [15:0] io_page_base, // io page base
	input wire logic [22:0] extended_data_stack_pointer, // data stack
	input wire logic [22:0] extended_system_stack_pointer // system stack
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	logic calm;
	assign calm = ded_wr.target == dptr_pkg::DW_NONE && !mmr.sel;

	a_abs_concat: assert property ($past(nrst) |-> abs_addr ==
		{$past(extended_page_value[22:16]), $past(absolute_16bit_immediate)})
		else $error("absolute address not page over immediate");
	a_read_sp: assert property (mmr.sel && !mmr.we &&
		mmr.addr == dptr_pkg::OFS_SP |=> mmr_hit &&
		mmr_rdata == $past(extended_data_stack_pointer[15:0]))
		else $error("stack pointer read wrong");
	a_unmapped_quiet: assert property (mmr.sel && mmr.addr == 16'h0050 |=>
		!mmr_hit && ($past(mmr.we) || mmr_rdata == 16'h0000))
		else $error("unmapped access answered");
	a_push_dec: assert property (dstk_op.push && !dstk_op.pop && calm |=>
		extended_data_stack_pointer ==
		{$past(extended_data_stack_pointer[22:16]),
		$past(extended_data_stack_pointer[15:0]) - 16'h0001})
		else $error("push did not decrement pointer only");
	a_pop_inc: assert property (sstk_op.pop && !sstk_op.push && calm |=>
		extended_system_stack_pointer ==
		{$past(extended_system_stack_pointer[22:16]),
		$past(extended_system_stack_pointer[15:0]) + 16'h0001})
		else $error("pop did not increment pointer only");
	a_page_shared: assert property (extended_data_stack_pointer[22:16] ==
		extended_system_stack_pointer[22:16])
		else $error("stack pages differ");
	a_io_write: assert property (mmr.sel && mmr.we &&
		mmr.addr == dptr_pkg::OFS_PDP && ded_wr.target == dptr_pkg::DW_NONE
		|=> io_page_base == {$past(mmr.wdata[8:0]), 7'h00})
		else $error("io page base wrong after write");
	a_coef_linear: assert property (agen.valid && !agen.circ_en &&
		agen.sel == dptr_pkg::SEL_COEF |=> agen_valid &&
		agen_addr == $past(extended_coef_pointer))
		else $error("linear coefficient address wrong");
	a_aux_linear: assert property (agen.valid && !agen.circ_en &&
		agen.sel < dptr_pkg::SEL_COEF |=> agen_valid &&
		agen_addr == $past(agen.aux_ptr))
		else $error("linear auxiliary address wrong");
endmodule : dptr_monitor

bind dsp_data_pointer_registers dptr_monitor mon (.sys_clk, .nrst, .mmr,
	.ded_wr, .dstk_op, .sstk_op, .agen, .absolute_16bit_immediate,
	.mmr_rdata, .mmr_hit, .agen_addr, .agen_valid, .extended_coef_pointer,
	.extended_page_value, .abs_addr, .io_page_base,
	.extended_data_stack_pointer, .extended_system_stack_pointer);

// >>> tb/agen_partner_model.sv
/*
 * Decoder-side model: eight extended auxiliary pointers and requests.
 * Assumes the bench sets request fields just after a rising edge.
 */
`timescale 1ns/100ps
module agen_partner_model (
	input wire logic sys_clk, // core clock
	input wire logic nrst, // reset, active low
	input wire logic go, // issue a request
	input wire logic [3:0] sel, // pointer select
	input wire logic circ_en, // pointer is circular
	input wire logic [15:0] step, // signed modifier
	input wire logic advance, // write back advanced index
	input wire logic agen_valid, // answer strobe
	input wire logic [15:0] agen_next_index, // advanced index
	output dptr_pkg::agen_req_t agen // request to the block
);
	logic [22:0] aux_r [8];
	logic [22:0] last_r;
	logic [2:0] sel_r;
	logic adv_r;
	always_comb begin
		agen.valid = go;
		agen.sel = sel;
		agen.circ_en = circ_en;
		agen.step = step;
		agen.advance = advance;
		// idle pointer lines carry inverted data
		agen.aux_ptr = go ? aux_r[sel[2:0]] : ~last_r;
	end
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			for (int i = 0; i < 8; i++) begin
				aux_r[i] <= {3'h1, 4'(i), 16'h0003};
			end
			last_r <= 23'h000000;
			sel_r <= 3'h0;
			adv_r <= 1'b0;
		end else begin
			adv_r <= go && advance && !sel[3];
			if (go) begin
				last_r <= agen.aux_ptr;
				sel_r <= sel[2:0];
			end
			if (agen_valid && adv_r) begin
				aux_r[sel_r][15:0] <= agen_next_index;
			end
		end
	end
endmodule : agen_partner_model

// >>> tb/dsp_data_pointer_registers_tb_top.sv
/*
 * Self-checking bench for the data pointer register block.
 * Assumes the package, the monitor and the decoder model are compiled.
 */
`timescale 1ns/100ps
module dsp_data_pointer_registers_tb_top;
	typedef struct packed {
		logic [15:0] a;
		logic [15:0] w;
		logic [15:0] r;
		logic h;
	} row_t;
	logic sys_clk = 1'b0;
	logic nrst = 1'b0;
	dptr_pkg::mmr_req_t mmr = '0;
	dptr_pkg::ded_wr_t ded_wr = '0;
	dptr_pkg::stk_op_t dstk_op = '0;
	dptr_pkg::stk_op_t sstk_op = '0;
	dptr_pkg::agen_req_t agen;
	logic legacy = 1'b0;
	logic [15:0] imm = 16'h0000;
	logic go = 1'b0;
	logic [3:0] sel = 4'h0;
	logic circ_en = 1'b0;
	logic [15:0] step = 16'h0000;
	logic advance = 1'b0;
	logic [15:0] mmr_rdata, next_index, io_page_base;
	logic mmr_hit, agen_valid;
	logic [22:0] agen_addr, xcoef, xpage, abs_addr, xdstk, xsstk;
	int err_count = 0;
	int checks_done = 0;
	int cycles = 0;
	row_t rows [17] = '{
		'{16'h0020, 16'h0020, 16'h0020, 1'b1},
		'{16'h004f, 16'hff85, 16'h0005, 1'b1},
		'{16'h0027, 16'h0001, 16'h0001, 1'b1},
		'{16'h0028, 16'hffff, 16'hffff, 1'b1},
		'{16'h0029, 16'h8001, 16'h8001, 1'b1},
		'{16'h002a, 16'h1000, 16'h1000, 1'b1},
		'{16'h002b, 16'hfff0, 16'hfff0, 1'b1},
		'{16'h0024, 16'h0008, 16'h0008, 1'b1},
		'{16'h0025, 16'h0005, 16'h0005, 1'b1},
		'{16'h0026, 16'h0000, 16'h0000, 1'b1},
		'{16'h0021, 16'h3456, 16'h3456, 1'b1},
		'{16'h0022, 16'hff8b, 16'h000b, 1'b1},
		'{16'h0023, 16'hffff, 16'h01ff, 1'b1},
		'{16'h004d, 16'h0100, 16'h0100, 1'b1},
		'{16'h004c, 16'h0200, 16'h0200, 1'b1},
		'{16'h004e, 16'h0092, 16'h0012, 1'b1},
		'{16'h0050, 16'hbeef, 16'h0000, 1'b0}};

	dsp_data_pointer_registers DUT (.sys_clk, .nrst, .mmr, .mmr_rdata,
		.mmr_hit, .ded_wr, .dstk_op, .sstk_op, .agen,
		.legacy_compat_mode(legacy), .absolute_16bit_immediate(imm),
		.agen_addr, .agen_next_index(next_index), .agen_valid,
		.extended_coef_pointer(xcoef), .extended_page_value(xpage),
		.abs_addr, .io_page_base, .extended_data_stack_pointer(xdstk),
		.extended_system_stack_pointer(xsstk));
	agen_partner_model decoder (.sys_clk, .nrst, .go, .sel, .circ_en,
		.step, .advance, .agen_valid, .agen_next_index(next_index), .agen);

	always #5 sys_clk = ~sys_clk;

	task automatic chk(input string nm, input logic [22:0] got, exp);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	task automatic acc(input logic we, input logic [15:0] a, w);
		@(posedge sys_clk);
		mmr <= '{1'b1, we, a, w};
		@(posedge sys_clk);
		mmr.sel <= 1'b0;
		#1;
	endtask : acc

	// s holds data push, data pop, system push, system pop
	task automatic strobe(input dptr_pkg::ded_target_t t,
		input logic [22:0] d, input logic [3:0] s);
		@(posedge sys_clk);
		ded_wr <= '{t, d};
		{dstk_op, sstk_op} <= s;
		@(posedge sys_clk);
		ded_wr.target <= dptr_pkg::DW_NONE;
		{dstk_op, sstk_op} <= 4'h0;
		#1;
	endtask : strobe

	task automatic gen(input logic [3:0] s, input logic c,
		input logic [15:0] st, input logic adv);
		@(posedge sys_clk);
		go <= 1'b1;
		{sel, circ_en, step, advance} <= {s, c, st, adv};
		@(posedge sys_clk);
		go <= 1'b0;
		#1;
		chk("agen valid", agen_valid, 23'h1);
	endtask : gen

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : tally_and_finish

	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 3000) begin
			err_count++;
			tally_and_finish();
		end
	end

	initial begin
		repeat (8) @(posedge sys_clk);
		nrst <= 1'b1;
		foreach (rows[i]) begin
			acc(1'b1, rows[i].a, rows[i].w);
			chk("write hit", mmr_hit, rows[i].h);
			acc(1'b0, rows[i].a, 16'h0000);
			chk("read data", mmr_rdata, rows[i].r);
			chk("read hit", mmr_hit, rows[i].h);
		end
		$display("register table done");
		@(posedge sys_clk);
		imm <= 16'habcd;
		@(posedge sys_clk);
		#1;
		chk("coef pointer", xcoef, {7'h05, 16'h0020});
		chk("page value", xpage, {7'h0b, 16'h3456});
		chk("absolute", abs_addr, {7'h0b, 16'habcd});
		chk("io base", io_page_base, 16'hff80);
		chk("data stack", xdstk, {7'h12, 16'h0100});
		chk("system stack", xsstk, {7'h12, 16'h0200});
		strobe(dptr_pkg::DW_NONE, 23'h0, 4'h8);
		chk("push", xdstk, {7'h12, 16'h00ff});
		strobe(dptr_pkg::DW_NONE, 23'h0, 4'h1);
		chk("pop", xsstk, {7'h12, 16'h0201});
		strobe(dptr_pkg::DW_EXT_SSTK, 23'h330040, 4'h0);
		chk("ext system", xsstk, 23'h330040);
		chk("shared page", xdstk, {7'h33, 16'h00ff});
		strobe(dptr_pkg::DW_IO_PAGE, 23'h000003, 4'h0);
		chk("io page", io_page_base, 16'h0180);
		$display("stack and concatenation done");
		gen(4'h6, 1'b1, 16'h0001, 1'b1);
		chk("circ addr", agen_addr, {7'h16, 16'h1003});
		chk("next index", next_index, 16'h0004);
		gen(4'h6, 1'b1, 16'h0001, 1'b1);
		chk("circ addr", agen_addr, {7'h16, 16'h1004});
		chk("wrap index", next_index, 16'h0000);
		acc(1'b1, 16'h002a, 16'h0000);
		@(posedge sys_clk);
		legacy <= 1'b1;
		gen(4'h6, 1'b1, 16'hffff, 1'b1);
		chk("legacy addr", agen_addr, {7'h16, 16'h0000});
		chk("legacy wrap", next_index, 16'h0007);
		@(posedge sys_clk);
		legacy <= 1'b0;
		gen(4'h8, 1'b1, 16'h0002, 1'b1);
		chk("coef circ", agen_addr, {7'h05, 16'h0010});
		chk("coef advance", xcoef, {7'h05, 16'h0022});
		gen(4'h8, 1'b0, 16'h0000, 1'b0);
		chk("coef linear", agen_addr, {7'h05, 16'h0022});
		gen(4'h2, 1'b0, 16'h0000, 1'b0);
		chk("aux linear", agen_addr, {7'h12, 16'h0003});
		strobe(dptr_pkg::DW_EXT_COEF, 23'h7f1234, 4'h0);
		chk("ext coef", xcoef, 23'h7f1234);
		acc(1'b0, 16'h004f, 16'h0000);
		chk("coef page read", mmr_rdata, 16'h007f);
		$display("address forming done");
		@(posedge sys_clk);
		nrst <= 1'b0;
		repeat (2) @(posedge sys_clk);
		nrst <= 1'b1;
		#1;
		chk("reset stack", xdstk, 23'h0);
		chk("reset coef", xcoef, 23'h0);
		chk("reset hit", mmr_hit, 23'h0);
		$display("reset done");
		tally_and_finish();
	end
endmodule : dsp_data_pointer_registers_tb_top
